// >>> hw/dmm_pkg.sv
// Package: register map, constants and carrier types of the data memory map
package dmm_pkg;
  // Bus register byte offsets
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_WDATA = 12'h008;
  localparam logic [11:0] REG_RDATA = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_STATUS_WORD = 12'h014;
  localparam logic [11:0] REG_STACK_PTR = 12'h018;
  localparam logic [11:0] REG_AUX_CTRL = 12'h01c;
  localparam logic [11:0] REG_DATA_PTR = 12'h020;
  localparam logic [11:0] REG_ACCUM = 12'h024;
  localparam logic [11:0] REG_B = 12'h028;
  localparam logic [11:0] REG_POWER = 12'h02c;
  // Special-function register direct addresses
  localparam logic [7:0] ADR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADR_POINTER_LO = 8'h82;
  localparam logic [7:0] ADR_POINTER_HI = 8'h83;
  localparam logic [7:0] ADR_POWER_CTRL = 8'h87;
  localparam logic [7:0] ADR_AUX_CTRL = 8'ha2;
  localparam logic [7:0] ADR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADR_ACCUMULATOR = 8'he0;
  localparam logic [7:0] ADR_B = 8'hf0;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0] STACK_RESET = 8'h07;
  // Field positions
  localparam int BANK_SELECT_LO_BIT = 3;
  localparam int BANK_SELECT_HI_BIT = 4;
  localparam int PARITY_BIT = 0;
  localparam int PTR_SELECT_BIT = 0;
  localparam int IDLE_BIT = 0;
  localparam int PDOWN_BIT = 1;
  localparam int STS_BUSY = 0;
  localparam int STS_FAULT = 1;
  localparam int STS_IDLE = 2;
  localparam int STS_PDOWN = 3;
  // Program space 8K bytes, auxiliary data space 0000h-00ffh
  localparam int CODE_ADDR_W = 13;
  localparam logic [15:0] CODE_LIMIT = 16'(1 << CODE_ADDR_W);
  localparam logic [15:0] AUX_LIMIT = 16'h0100;

  typedef enum logic [3:0] {
    OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR, OP_REG_RD, OP_REG_WR,
    OP_BIT_RD, OP_BIT_WR, OP_PUSH, OP_POP, OP_CALL, OP_EXT_RD, OP_EXT_WR,
    OP_CODE_RD
  } dmm_op_t;

  typedef enum logic {ST_READY, ST_CALL_HI} dmm_state_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } dmm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dmm_apb_rsp_t;
endpackage

// >>> hw/dmm_byte_ram.sv
// Flip-flop byte store with two read ports and one write port
`timescale 1ns/1ps
module dmm_byte_ram #(
  parameter int unsigned DEPTH = 256
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] rd_a_idx_in,
  output logic [7:0] rd_a_data_out,
  input wire logic [7:0] rd_b_idx_in,
  output logic [7:0] rd_b_data_out
);
  import dmm_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } dmm_ram_state_t;

  dmm_ram_state_t st_q;
  dmm_ram_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (wr_en_in && (32'(wr_idx_in) < DEPTH)) begin
      st_d.mem[wr_idx_in] = wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Out-of-range indices read as zero
  assign rd_a_data_out = (32'(rd_a_idx_in) < DEPTH) ? st_q.mem[rd_a_idx_in] : 8'h00;
  assign rd_b_data_out = (32'(rd_b_idx_in) < DEPTH) ? st_q.mem[rd_b_idx_in] : 8'h00;
endmodule

// >>> hw/dmm_data_memory_map.sv
// Data memory map: scratch-pad, banks, bit space, stack, pointers, power gating
`timescale 1ns/1ps
// Overview of operation
// - Four banks of eight byte registers
// - Two status-word bits pick active bank
// - First two bank registers act as pointers
// - Bytes 20h-2Fh byte and bit addressable
// - Registers at x0h/x8h are bit addressable
// - Operation type alone selects bit or byte
// - Registers direct only, RAM 00h-7Fh direct or indirect, 80h-FFh indirect only
// - Scratch-pad RAM holds 256 bytes
// - Stack pointer resets to 07h, writable
// - Push increments pointer, then writes
// - Pop reads first, then decrements
// - Call pushes the return address
// - Stack may start anywhere in RAM
// - Auxiliary RAM 0000h-00FFh via external move
// - Auxiliary RAM never fetched, no overlap
// - Program space up to 8K, table-readable
// - Two 16-bit pointers, select bit 0
// - Status word holds ALU flags and bank
// - B register is second multiply operand
// - Idle stops core clock only
// - Power-down stops all clocks
// - Registers at direct addresses 80h-FFh
module dmm_data_memory_map #(
  parameter int unsigned SCRATCH_DEPTH = 256,
  parameter int unsigned AUX_DEPTH = 256
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire dmm_pkg::dmm_apb_req_t apb_req_in,
  output dmm_pkg::dmm_apb_rsp_t apb_rsp_out,
  input wire logic [7:0] code_data_in,
  input wire logic wake_in,
  output logic [dmm_pkg::CODE_ADDR_W-1:0] code_addr_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out
);
  import dmm_pkg::*;

  typedef struct packed {
    dmm_state_t fsm;
    dmm_op_t last_op;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [7:0] rdata;
    logic fault;
    logic [7:0] stack_pointer_reg;
    logic [7:0] program_status_word;
    logic [7:0] accumulator_reg;
    logic [7:0] b_reg;
    logic pointer_select_bit;
    logic [15:0] data_pointer_pair0;
    logic [15:0] data_pointer_pair1;
    logic idle;
    logic pdown;
    logic [7:0] ret_hi;
    logic [31:0] prdata;
  } dmm_core_state_t;

  localparam dmm_core_state_t CORE_RESET = '{
    fsm: ST_READY, last_op: OP_DIR_RD, stack_pointer_reg: STACK_RESET, default: '0
  };

  dmm_core_state_t st_q;
  dmm_core_state_t st_d;
  logic acc_phase, reg_wr, launch;
  dmm_op_t op;
  logic [15:0] data_pointer_pair_act, code_sum;
  logic [7:0] bit_byte, special_bit_src, bit_src, bit_mod;
  logic [7:0] scr_ridx, scr_rdat, ptr_ridx, ptr_rdat, scr_widx, scr_wdat;
  logic scr_we, aux_we;
  logic [7:0] aux_rdat;
  logic sfr_we;
  logic [7:0] sfr_wa, sfr_wv;
  logic [31:0] read_mux;
  logic [3:0] status_w;

  function automatic logic [7:0] bank_idx(input logic [7:0] sw, input logic [2:0] r);
    return {3'b000, sw[BANK_SELECT_HI_BIT], sw[BANK_SELECT_LO_BIT], r};
  endfunction

  function automatic logic special_impl(input logic [7:0] a);
    logic r;
    r = 1'b0;
    unique case (a)
      ADR_STACK_POINTER, ADR_POINTER_LO, ADR_POINTER_HI, ADR_POWER_CTRL,
      ADR_AUX_CTRL, ADR_STATUS_WORD, ADR_ACCUMULATOR, ADR_B: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] special_rd(input logic [7:0] a, input dmm_core_state_t s);
    logic [15:0] d;
    logic [7:0] r;
    d = s.pointer_select_bit ? s.data_pointer_pair1 : s.data_pointer_pair0;
    r = 8'h00;
    unique case (a)
      ADR_STACK_POINTER: r = s.stack_pointer_reg;
      ADR_POINTER_LO: r = d[7:0];
      ADR_POINTER_HI: r = d[15:8];
      ADR_POWER_CTRL: begin
        r[IDLE_BIT] = s.idle;
        r[PDOWN_BIT] = s.pdown;
      end
      ADR_AUX_CTRL: r[PTR_SELECT_BIT] = s.pointer_select_bit;
      // Parity always follows the accumulator
      ADR_STATUS_WORD: begin
        r = s.program_status_word;
        r[PARITY_BIT] = ^s.accumulator_reg;
      end
      ADR_ACCUMULATOR: r = s.accumulator_reg;
      ADR_B: r = s.b_reg;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic reg_mapped(input logic [11:0] a);
    logic r;
    unique case (a)
      REG_CMD, REG_ADDR, REG_WDATA, REG_RDATA, REG_STATUS, REG_STATUS_WORD, REG_STACK_PTR,
      REG_AUX_CTRL, REG_DATA_PTR, REG_ACCUM, REG_B, REG_POWER: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign acc_phase = apb_req_in.psel & apb_req_in.penable;
  assign reg_wr = acc_phase & apb_req_in.pwrite & (st_q.fsm == ST_READY);
  assign launch = reg_wr & (apb_req_in.paddr == REG_CMD) & ~st_q.idle & ~st_q.pdown;
  assign op = dmm_op_t'(apb_req_in.pwdata[3:0]);
  assign data_pointer_pair_act = st_q.pointer_select_bit ? st_q.data_pointer_pair1 : st_q.data_pointer_pair0;
  assign code_sum = data_pointer_pair_act + {8'h00, st_q.accumulator_reg};
  assign bit_byte = st_q.addr[7] ? {st_q.addr[7:3], 3'b000} :
                    BIT_BYTE_BASE + {4'h0, st_q.addr[6:3]};
  assign ptr_ridx = bank_idx(st_q.program_status_word, {2'b00, st_q.addr[0]});
  assign special_bit_src = special_rd(bit_byte, st_q);
  assign bit_src = st_q.addr[7] ? special_bit_src : scr_rdat;

  always_comb begin
    bit_mod = bit_src;
    bit_mod[st_q.addr[2:0]] = st_q.wdata[0];
  end

  always_comb begin
    unique case (op)
      OP_IND_RD, OP_IND_WR: scr_ridx = ptr_rdat;
      OP_REG_RD, OP_REG_WR: scr_ridx = bank_idx(st_q.program_status_word, st_q.addr[2:0]);
      OP_BIT_RD, OP_BIT_WR: scr_ridx = bit_byte;
      OP_POP: scr_ridx = st_q.stack_pointer_reg;
      default: scr_ridx = st_q.addr;
    endcase
  end

  always_comb begin
    status_w = 4'h0;
    status_w[STS_BUSY] = (st_q.fsm != ST_READY);
    status_w[STS_FAULT] = st_q.fault;
    status_w[STS_IDLE] = st_q.idle;
    status_w[STS_PDOWN] = st_q.pdown;
  end

  always_comb begin
    unique case (apb_req_in.paddr)
      REG_CMD: read_mux = {28'h0000000, st_q.last_op};
      REG_ADDR: read_mux = {24'h000000, st_q.addr};
      REG_WDATA: read_mux = {16'h0000, st_q.wdata};
      REG_RDATA: read_mux = {24'h000000, st_q.rdata};
      REG_STATUS: read_mux = {28'h0000000, status_w};
      REG_STATUS_WORD: read_mux = {24'h000000, special_rd(ADR_STATUS_WORD, st_q)};
      REG_STACK_PTR: read_mux = {24'h000000, st_q.stack_pointer_reg};
      REG_AUX_CTRL: read_mux = {24'h000000, special_rd(ADR_AUX_CTRL, st_q)};
      REG_DATA_PTR: read_mux = {16'h0000, data_pointer_pair_act};
      REG_ACCUM: read_mux = {24'h000000, st_q.accumulator_reg};
      REG_B: read_mux = {24'h000000, st_q.b_reg};
      REG_POWER: read_mux = {24'h000000, special_rd(ADR_POWER_CTRL, st_q)};
      default: read_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    st_d = st_q;
    scr_we = 1'b0;
    scr_widx = scr_ridx;
    scr_wdat = st_q.wdata[7:0];
    aux_we = 1'b0;
    sfr_we = 1'b0;
    sfr_wa = 8'h00;
    sfr_wv = apb_req_in.pwdata[7:0];
    // Read data is latched in the setup cycle
    if (apb_req_in.psel && !apb_req_in.penable) begin
      st_d.prdata = read_mux;
    end
    if (reg_wr) begin
      sfr_we = 1'b1;
      unique case (apb_req_in.paddr)
        REG_ADDR: st_d.addr = apb_req_in.pwdata[7:0];
        REG_WDATA: st_d.wdata = apb_req_in.pwdata[15:0];
        REG_DATA_PTR: begin
          if (st_q.pointer_select_bit) begin
            st_d.data_pointer_pair1 = apb_req_in.pwdata[15:0];
          end else begin
            st_d.data_pointer_pair0 = apb_req_in.pwdata[15:0];
          end
        end
        REG_STATUS_WORD: sfr_wa = ADR_STATUS_WORD;
        REG_STACK_PTR: sfr_wa = ADR_STACK_POINTER;
        REG_AUX_CTRL: sfr_wa = ADR_AUX_CTRL;
        REG_ACCUM: sfr_wa = ADR_ACCUMULATOR;
        REG_B: sfr_wa = ADR_B;
        REG_POWER: sfr_wa = ADR_POWER_CTRL;
        default: sfr_we = 1'b0;
      endcase
    end
    unique case (st_q.fsm)
      ST_READY: begin
        if (launch) begin
          st_d.last_op = op;
          st_d.fault = 1'b0;
          sfr_we = 1'b0;
          sfr_wv = st_q.wdata[7:0];
          unique case (op)
            OP_DIR_RD: begin
              if (!st_q.addr[7]) begin
                st_d.rdata = scr_rdat;
              end else if (special_impl(st_q.addr)) begin
                st_d.rdata = special_rd(st_q.addr, st_q);
              end else begin
                st_d.fault = 1'b1;
              end
            end
            OP_DIR_WR: begin
              if (!st_q.addr[7]) begin
                scr_we = 1'b1;
              end else if (special_impl(st_q.addr)) begin
                sfr_we = 1'b1;
                sfr_wa = st_q.addr;
              end else begin
                st_d.fault = 1'b1;
              end
            end
            OP_IND_RD, OP_REG_RD: st_d.rdata = scr_rdat;
            OP_IND_WR, OP_REG_WR: scr_we = 1'b1;
            OP_BIT_RD: begin
              if (!st_q.addr[7] || special_impl(bit_byte)) begin
                st_d.rdata = {7'h00, bit_src[st_q.addr[2:0]]};
              end else begin
                st_d.fault = 1'b1;
              end
            end
            OP_BIT_WR: begin
              scr_wdat = bit_mod;
              if (!st_q.addr[7]) begin
                scr_we = 1'b1;
              end else if (special_impl(bit_byte)) begin
                sfr_we = 1'b1;
                sfr_wa = bit_byte;
                sfr_wv = bit_mod;
              end else begin
                st_d.fault = 1'b1;
              end
            end
            OP_PUSH, OP_CALL: begin
              scr_we = 1'b1;
              scr_widx = st_q.stack_pointer_reg + 8'h01;
              st_d.stack_pointer_reg = scr_widx;
              if (op == OP_CALL) begin
                st_d.ret_hi = st_q.wdata[15:8];
                st_d.fsm = ST_CALL_HI;
              end
            end
            OP_POP: begin
              st_d.rdata = scr_rdat;
              st_d.stack_pointer_reg = st_q.stack_pointer_reg - 8'h01;
            end
            OP_EXT_RD, OP_EXT_WR: begin
              if (data_pointer_pair_act >= AUX_LIMIT) begin
                st_d.fault = 1'b1;
              end else if (op == OP_EXT_WR) begin
                aux_we = 1'b1;
              end else begin
                st_d.rdata = aux_rdat;
              end
            end
            OP_CODE_RD: begin
              if (code_sum < CODE_LIMIT) begin
                st_d.rdata = code_data_in;
              end else begin
                st_d.fault = 1'b1;
              end
            end
            default: st_d.fault = 1'b1;
          endcase
        end
      end
      ST_CALL_HI: begin
        scr_we = 1'b1;
        scr_widx = st_q.stack_pointer_reg + 8'h01;
        scr_wdat = st_q.ret_hi;
        st_d.stack_pointer_reg = scr_widx;
        st_d.fsm = ST_READY;
      end
    endcase
    if (sfr_we) begin
      unique case (sfr_wa)
        ADR_STACK_POINTER: st_d.stack_pointer_reg = sfr_wv;
        ADR_POINTER_LO: begin
          if (st_q.pointer_select_bit) begin
            st_d.data_pointer_pair1[7:0] = sfr_wv;
          end else begin
            st_d.data_pointer_pair0[7:0] = sfr_wv;
          end
        end
        ADR_POINTER_HI: begin
          if (st_q.pointer_select_bit) begin
            st_d.data_pointer_pair1[15:8] = sfr_wv;
          end else begin
            st_d.data_pointer_pair0[15:8] = sfr_wv;
          end
        end
        ADR_POWER_CTRL: begin
          st_d.idle = sfr_wv[IDLE_BIT];
          st_d.pdown = sfr_wv[PDOWN_BIT];
        end
        ADR_AUX_CTRL: st_d.pointer_select_bit = sfr_wv[PTR_SELECT_BIT];
        ADR_STATUS_WORD: st_d.program_status_word = sfr_wv;
        ADR_ACCUMULATOR: st_d.accumulator_reg = sfr_wv;
        ADR_B: st_d.b_reg = sfr_wv;
        default: st_d.fault = st_d.fault;
      endcase
    end
    if (wake_in) begin
      st_d.idle = 1'b0;
      st_d.pdown = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= CORE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // scratch-pad store, stack anywhere in it
  dmm_byte_ram #(.DEPTH(SCRATCH_DEPTH)) u_scratch (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(scr_we),
    .wr_idx_in(scr_widx),
    .wr_data_in(scr_wdat),
    .rd_a_idx_in(scr_ridx),
    .rd_a_data_out(scr_rdat),
    .rd_b_idx_in(ptr_ridx),
    .rd_b_data_out(ptr_rdat)
  );

  // auxiliary store has no fetch path
  dmm_byte_ram #(.DEPTH(AUX_DEPTH)) u_aux (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(aux_we),
    .wr_idx_in(data_pointer_pair_act[7:0]),
    .wr_data_in(st_q.wdata[7:0]),
    .rd_a_idx_in(data_pointer_pair_act[7:0]),
    .rd_a_data_out(aux_rdat),
    .rd_b_idx_in(8'h00),
    .rd_b_data_out()
  );

  assign apb_rsp_out.prdata = st_q.prdata;
  assign apb_rsp_out.pready = 1'b1;
  assign apb_rsp_out.pslverr = acc_phase & ~reg_mapped(apb_req_in.paddr);
  assign code_addr_out = code_sum[CODE_ADDR_W-1:0];
  assign cpu_clk_en_out = ~(st_q.idle | st_q.pdown);
  assign periph_clk_en_out = ~st_q.pdown;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  push_order_a: assert property (
    launch && op == OP_PUSH |-> scr_we && scr_widx == st_q.stack_pointer_reg + 8'h01
      ##1 st_q.stack_pointer_reg == $past(scr_widx))
    else $error("push did not pre-increment");
  pop_order_a: assert property (
    launch && op == OP_POP |-> !scr_we && scr_ridx == st_q.stack_pointer_reg
      ##1 st_q.stack_pointer_reg == $past(st_q.stack_pointer_reg) - 8'h01
      && st_q.rdata == $past(scr_rdat))
    else $error("pop order wrong");
  call_push_a: assert property (
    launch && op == OP_CALL |=> st_q.fsm == ST_CALL_HI && scr_wdat == st_q.ret_hi
      ##1 st_q.fsm == ST_READY && st_q.stack_pointer_reg == $past(st_q.stack_pointer_reg, 2) + 8'h02)
    else $error("call push wrong");
  bank_pick_a: assert property (
    launch && op == OP_REG_RD |-> scr_ridx[4:3] == st_q.program_status_word[4:3]
      && scr_ridx[2:0] == st_q.addr[2:0] && scr_ridx[7:5] == 3'b000)
    else $error("bank index wrong");
  bit_map_a: assert property (
    launch && op == OP_BIT_RD && !st_q.addr[7] |-> scr_ridx == 8'h20 + {4'h0, st_q.addr[6:3]}
      ##1 st_q.rdata == {7'h00, $past(scr_rdat[st_q.addr[2:0]])})
    else $error("bit mapping wrong");
  direct_upper_a: assert property (
    launch && (op == OP_DIR_WR || op == OP_DIR_RD) && st_q.addr[7] |-> !scr_we)
    else $error("direct access hit upper RAM");
  aux_only_a: assert property (
    aux_we |-> launch && op == OP_EXT_WR && data_pointer_pair_act < 16'h0100)
    else $error("auxiliary write without move");
  idle_gate_a: assert property (
    st_q.idle && !st_q.pdown |-> !cpu_clk_en_out && periph_clk_en_out)
    else $error("idle gating wrong");
  pdown_gate_a: assert property (
    $rose(st_q.pdown) |-> !periph_clk_en_out && !cpu_clk_en_out [*2] or wake_in)
    else $error("power-down gating wrong");
  table_read_a: assert property (
    launch && op == OP_CODE_RD && code_sum < 16'h2000 |=> st_q.rdata == $past(code_data_in))
    else $error("table read wrong");

  cover property (launch && op == OP_CALL ##2 st_q.fsm == ST_READY);
  cover property (launch && op == OP_POP && st_q.stack_pointer_reg == 8'h08);
  cover property (launch && op == OP_BIT_WR && st_q.addr[7] && !st_d.fault);
  cover property (launch && op == OP_EXT_RD && st_q.pointer_select_bit);
endmodule

// >>> verif/dmm_data_memory_map_test.sv
// Self-checking bench of the data memory map block
`timescale 1ns/1ps
module dmm_data_memory_map_test;
  import dmm_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  dmm_apb_req_t req = '0;
  dmm_apb_rsp_t rsp;
  logic [7:0] code_data_in = 8'h00;
  logic wake_in = 1'b0;
  logic [CODE_ADDR_W-1:0] code_addr;
  logic cpu_en;
  logic per_en;
  logic [31:0] rd;
  logic err;
  logic [7:0] stk [$];
  logic [7:0] lfsr = 8'h35;
  logic [7:0] v;
  logic [7:0] ba;
  logic [7:0] bits [3] = '{8'h00, 8'h0b, 8'h7f};
  logic [7:0] mem [256];
  logic [7:0] aux [256];
  int fails = 0;
  int check_count = 0;
  int cyc = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  dmm_data_memory_map i_dut (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .apb_req_in(req),
    .apb_rsp_out(rsp),
    .code_data_in(code_data_in),
    .wake_in(wake_in),
    .code_addr_out(code_addr),
    .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en)
  );

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_sys_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 64);
    if (n == 64) fails++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk_sys_in);
  endtask

  task automatic op(input dmm_op_t c, input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, REG_ADDR, {24'h0, a});
    apb(1'b1, REG_WDATA, {16'h0, d});
    apb(1'b1, REG_CMD, {28'h0, c});
  endtask

  task automatic res(input dmm_op_t c, input logic [7:0] a);
    op(c, a, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
      aux[i] = 8'h00;
    end
    repeat (16) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    apb(1'b0, REG_STACK_PTR, 32'h0);
    chk("stack ptr", 32'h07, rd);
    res(OP_DIR_RD, ADR_STACK_POINTER);
    chk("direct sfr", 32'h07, rd);
    $display("reset test done");
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, REG_STATUS_WORD, 32'(b << BANK_SELECT_LO_BIT));
      v = rnd();
      mem[b * 8 + 5] = v;
      op(OP_REG_WR, 8'h5, {8'h0, v});
    end
    for (int b = 0; b < 4; b++) begin
      res(OP_DIR_RD, 8'(b * 8 + 5));
      chk("bank reg", {24'h0, mem[b * 8 + 5]}, rd);
    end
    res(OP_REG_RD, 8'h5);
    chk("reg rd", {24'h0, mem[29]}, rd);
    op(OP_REG_WR, 8'h1, 16'h009c);
    v = rnd();
    mem[8'h9c] = v;
    op(OP_IND_WR, 8'h1, {8'h0, v});
    res(OP_IND_RD, 8'h1);
    chk("indirect", {24'h0, v}, rd);
    $display("bank test done");
    foreach (bits[i]) begin
      ba = bits[i];
      op(OP_BIT_WR, ba, 16'h1);
      mem[8'h20 + ba[6:3]][ba[2:0]] = 1'b1;
      res(OP_DIR_RD, 8'h20 + {4'h0, ba[6:3]});
      chk("bit byte", {24'h0, mem[8'h20 + ba[6:3]]}, rd);
      res(OP_BIT_RD, ba);
      chk("bit rd", 32'h1, rd);
    end
    op(OP_BIT_WR, 8'hf3, 16'h1);
    apb(1'b0, REG_B, 32'h0);
    chk("sfr bit", 32'h08, rd);
    op(OP_BIT_WR, 8'h83, 16'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("bit fault", 32'h2, rd);
    $display("bit test done");
    apb(1'b1, REG_STACK_PTR, 32'hf0);
    v = rnd();
    op(OP_CALL, 8'h30, {v, 8'h5a});
    stk.push_back(8'h5a);
    stk.push_back(v);
    apb(1'b0, REG_STACK_PTR, 32'h0);
    chk("sp call", 32'hf2, rd);
    res(OP_POP, 8'h30);
    chk("pop hi", {24'h0, stk.pop_back()}, rd);
    res(OP_POP, 8'h30);
    chk("pop lo", {24'h0, stk.pop_back()}, rd);
    op(OP_REG_WR, 8'h1, 16'h00f1);
    op(OP_PUSH, 8'h21, {8'h0, mem[8'h21]});
    res(OP_IND_RD, 8'h1);
    chk("push", {24'h0, mem[8'h21]}, rd);
    $display("stack test done");
    v = rnd();
    mem[8'h45] = v;
    op(OP_DIR_WR, 8'h45, {8'h0, v});
    res(OP_DIR_RD, 8'h45);
    chk("direct ram", {24'h0, mem[8'h45]}, rd);
    op(OP_DIR_WR, 8'h90, 16'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("direct fault", 32'h2, rd);
    chk("mapped err", 32'h0, 32'(err));
    op(OP_DIR_WR, ADR_ACCUMULATOR, 16'h00a5);
    apb(1'b0, REG_ACCUM, 32'h0);
    chk("direct sfr wr", 32'ha5, rd);
    apb(1'b1, REG_CMD, 32'he);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("bad opcode", 32'h2, rd);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped rd", 32'h0, rd);
    $display("direct test done");
    apb(1'b1, REG_AUX_CTRL, 32'h1);
    apb(1'b1, REG_DATA_PTR, 32'h0040);
    aux[8'h40] = rnd();
    op(OP_EXT_WR, 8'h0, {8'h0, aux[8'h40]});
    apb(1'b1, REG_AUX_CTRL, 32'h0);
    apb(1'b1, REG_DATA_PTR, 32'h00c5);
    aux[8'hc5] = rnd();
    op(OP_EXT_WR, 8'h0, {8'h0, aux[8'hc5]});
    apb(1'b1, REG_AUX_CTRL, 32'h1);
    apb(1'b0, REG_DATA_PTR, 32'h0);
    chk("ptr sel", 32'h0040, rd);
    res(OP_EXT_RD, 8'h0);
    chk("aux rd", {24'h0, aux[8'h40]}, rd);
    apb(1'b1, REG_AUX_CTRL, 32'h0);
    res(OP_EXT_RD, 8'h0);
    chk("aux rd", {24'h0, aux[8'hc5]}, rd);
    apb(1'b1, REG_DATA_PTR, 32'h0100);
    res(OP_EXT_RD, 8'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("aux fault", 32'h2, rd);
    apb(1'b1, REG_DATA_PTR, 32'h1ff0);
    apb(1'b1, REG_ACCUM, 32'h0f);
    chk("code addr", 32'h1fff, 32'(code_addr));
    v = rnd();
    code_data_in <= v;
    res(OP_CODE_RD, 8'h0);
    chk("code rd", {24'h0, v}, rd);
    apb(1'b1, REG_ACCUM, 32'h07);
    apb(1'b0, REG_STATUS_WORD, 32'h0);
    chk("status word", 32'h19, rd);
    $display("pointer test done");
    apb(1'b1, REG_POWER, 32'h1);
    chk("idle cpu", 32'h0, 32'(cpu_en));
    chk("idle per", 32'h1, 32'(per_en));
    apb(1'b1, REG_CMD, {28'h0, OP_DIR_RD});
    apb(1'b0, REG_CMD, 32'h0);
    chk("idle cmd", {28'h0, OP_CODE_RD}, rd);
    wake_in <= 1'b1;
    @(posedge clk_sys_in);
    wake_in <= 1'b0;
    @(posedge clk_sys_in);
    chk("wake cpu", 32'h1, 32'(cpu_en));
    apb(1'b1, REG_POWER, 32'h2);
    chk("pd cpu", 32'h0, 32'(cpu_en));
    chk("pd per", 32'h0, 32'(per_en));
    $display("power test done");
    stop_test();
  end
endmodule
